// File: core/prs_pkg.sv
// shared constants and state types for the power-up reset sequencer
package prs_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 8;

  // power-up reset must be done within this time of enable assertion
  localparam int unsigned POR_MAX_NS = 1300000;
  localparam int unsigned POR_MAX_CYC = POR_MAX_NS / CLK_PERIOD_NS;
  // cycles lost in the enable synchroniser and state entry
  localparam int unsigned POR_SYNC_MARGIN = 4;
  localparam int unsigned POR_DONE_CYC = POR_MAX_CYC - POR_SYNC_MARGIN;

  // least synthesiser settling time the host waits
  localparam int unsigned SETTLE_MIN_NS = 100000;
  localparam int unsigned SETTLE_CYC = (SETTLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // stability counts for the clock sources
  localparam int unsigned XTAL_STABLE_CYC = 64;
  localparam int unsigned SYNTH_STABLE_CYC = 128;

  // length of a reset pulse on the chip enable pin
  localparam int unsigned CE_PULSE_CYC = 8;

  // widths
  localparam int unsigned CFG_W = 32;
  localparam int unsigned NUM_BLK = 3;

  // block indices
  localparam int unsigned BLK_MEDIA_ACCESS = 0;
  localparam int unsigned BLK_RADIO_BASEBAND = 1;
  localparam int unsigned BLK_SYSTEM = 2;

  // device sequencer states
  typedef enum logic [2:0] {
    DS_HOLD,
    DS_POR,
    DS_OFF,
    DS_XTAL,
    DS_SYNTH,
    DS_RUN
  } prs_dev_state_t;

  // host sequencer states
  typedef enum logic [2:0] {
    HS_OFF,
    HS_PULSE,
    HS_WAIT_POR,
    HS_CFG,
    HS_CFG_END,
    HS_SETTLE,
    HS_FULL,
    HS_RUN
  } prs_host_state_t;

endpackage

// File: core/prs_link_if.sv
// link between the host and the sequenced device
`timescale 1ns/100ps
interface prs_link_if import prs_pkg::*; #(
  parameter int unsigned CFG_BITS = CFG_W
);
  // host to device
  logic chip_enable_pin;
  logic comm_req;
  logic cfg_valid;
  logic [CFG_BITS-1:0] cfg_data;
  logic full_speed_sel;
  // device to host
  logic por_done;
  logic cfg_ack;
  logic clocks_stable;
  logic blocks_run;

  modport dev (
    input chip_enable_pin,
    input comm_req,
    input cfg_valid,
    input cfg_data,
    input full_speed_sel,
    output por_done,
    output cfg_ack,
    output clocks_stable,
    output blocks_run
  );

  modport host (
    output chip_enable_pin,
    output comm_req,
    output cfg_valid,
    output cfg_data,
    output full_speed_sel,
    input por_done,
    input cfg_ack,
    input clocks_stable,
    input blocks_run
  );
endinterface

// File: core/prs_device.sv
// device end: power-up, reset and clock bring-up sequencer
`timescale 1ns/100ps
// Overview of operation
// - enable held low keeps everything off
// - low pulse on enable restarts whole sequence
// - power-up reset done within 1.3 ms
// - host loads synth setup before full speed
// - logic runs from crystal until full speed
// - host waits 100 us synth settling
// - after reset release wait in off state
// - off state: blocks unpowered, held in reset
// - crystal enabled first, then frequency synth
// - block resets released once clocks stable
// - sleep requests gate block clocks and power
module prs_device import prs_pkg::*; #(
  parameter int unsigned POR_CYCLES = POR_DONE_CYC,
  parameter int unsigned XTAL_CYCLES = XTAL_STABLE_CYC,
  parameter int unsigned SYNTH_CYCLES = SYNTH_STABLE_CYC,
  parameter int unsigned NBLK = NUM_BLK,
  parameter int unsigned CFG_BITS = CFG_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link to host
  prs_link_if.dev lnk,
  // internal modules
  input wire logic [NBLK-1:0] sleep_req,
  output logic [NBLK-1:0] blk_clk_en,
  output logic [NBLK-1:0] blk_pwr_en,
  output logic [NBLK-1:0] blk_rst_n,
  // clock sources
  output logic xtal_en,
  output logic frequency_synth_en,
  output logic clk_full_sel,
  output logic [CFG_BITS-1:0] frequency_synth_cfg
);

  typedef struct packed {
    logic [1:0] ce_s;
    logic [1:0] comm_s;
    logic [1:0] val_s;
    logic [1:0] full_s;
    logic [CFG_BITS-1:0] data_s0;
    logic [CFG_BITS-1:0] data_s1;
    prs_dev_state_t state;
    logic [31:0] cnt;
    logic por_done;
    logic cfg_ack;
    logic xtal_en;
    logic synth_en;
    logic stable;
    logic run;
    logic clk_full;
    logic [CFG_BITS-1:0] cfg;
    logic [NBLK-1:0] clk_en;
    logic [NBLK-1:0] pwr_en;
    logic [NBLK-1:0] rst_n;
  } prs_dev_reg_t;

  prs_dev_reg_t r;
  prs_dev_reg_t n;

  logic ce;
  logic comm;
  logic val;
  logic full;

  // count reached its programmed length
  function automatic logic cnt_done(
    input logic [31:0] cnt,
    input int unsigned cycles
  );
    return cnt >= 32'(cycles - 1);
  endfunction

  always_comb begin
    n = r;
    // synchronisers, first stage feeds only the second
    n.ce_s = {r.ce_s[0], lnk.chip_enable_pin};
    n.comm_s = {r.comm_s[0], lnk.comm_req};
    n.val_s = {r.val_s[0], lnk.cfg_valid};
    n.full_s = {r.full_s[0], lnk.full_speed_sel};
    n.data_s0 = lnk.cfg_data;
    n.data_s1 = r.data_s0;
    ce = r.ce_s[1];
    comm = r.comm_s[1];
    val = r.val_s[1];
    full = r.full_s[1];

    if (!ce) begin
      // device held fully off while enable is low
      n.state = DS_HOLD;
      n.cnt = 32'h0;
      n.por_done = 1'b0;
      n.cfg_ack = 1'b0;
      n.xtal_en = 1'b0;
      n.synth_en = 1'b0;
      n.stable = 1'b0;
      n.run = 1'b0;
      n.clk_full = 1'b0;
      n.clk_en = '0;
      n.pwr_en = '0;
      n.rst_n = '0;
      // setup word lost with the reset
      n.cfg = '0;
    end else begin
      // synth setup download handshake
      if (val && !r.cfg_ack) begin
        n.cfg_ack = 1'b1;
        // refused before reset done or after full speed
        if (r.por_done && !r.clk_full) begin
          n.cfg = r.data_s1;
        end
      end else if (!val) begin
        n.cfg_ack = 1'b0;
      end

      // full speed only once the synth is stable
      n.clk_full = full && r.stable;

      case (r.state)
        DS_HOLD: begin
          // fresh sequence after enable rises
          n.state = DS_POR;
          n.cnt = 32'h0;
        end
        DS_POR: begin
          n.cnt = r.cnt + 32'h1;
          if (cnt_done(r.cnt, POR_CYCLES)) begin
            n.por_done = 1'b1;
            n.cnt = 32'h0;
            n.state = DS_OFF;
          end
        end
        DS_OFF: begin
          // blocks stay unpowered and in reset here
          n.clk_en = '0;
          n.pwr_en = '0;
          n.rst_n = '0;
          if (comm) begin
            n.xtal_en = 1'b1;
            n.cnt = 32'h0;
            n.state = DS_XTAL;
          end
        end
        DS_XTAL: begin
          n.cnt = r.cnt + 32'h1;
          if (cnt_done(r.cnt, XTAL_CYCLES)) begin
            // synth only after crystal counted stable
            n.synth_en = 1'b1;
            n.cnt = 32'h0;
            n.state = DS_SYNTH;
          end
        end
        DS_SYNTH: begin
          n.cnt = r.cnt + 32'h1;
          if (cnt_done(r.cnt, SYNTH_CYCLES)) begin
            n.stable = 1'b1;
            n.pwr_en = '1;
            n.cnt = 32'h0;
            n.state = DS_RUN;
          end
        end
        DS_RUN: begin
          n.run = 1'b1;
          for (int i = 0; i < int'(NBLK); i++) begin
            // sleep: clock off, then power; wake: power, then clock
            n.clk_en[i] = !sleep_req[i] && r.pwr_en[i];
            n.pwr_en[i] = !sleep_req[i] || r.clk_en[i];
            // reset released once clocks stable and block powered
            n.rst_n[i] = r.stable && r.pwr_en[i];
          end
        end
        default: begin
          n.state = DS_HOLD;
          n.cnt = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // link outputs
  assign lnk.por_done = r.por_done;
  assign lnk.cfg_ack = r.cfg_ack;
  assign lnk.clocks_stable = r.stable;
  assign lnk.blocks_run = r.run;

  // user side outputs
  assign blk_clk_en = r.clk_en;
  assign blk_pwr_en = r.pwr_en;
  assign blk_rst_n = r.rst_n;
  assign xtal_en = r.xtal_en;
  assign frequency_synth_en = r.synth_en;
  assign clk_full_sel = r.clk_full;
  assign frequency_synth_cfg = r.cfg;

endmodule // prs_device

// File: core/prs_host.sv
// host end: drives chip enable and the bring-up download sequence
`timescale 1ns/100ps
module prs_host import prs_pkg::*; #(
  parameter int unsigned PULSE_CYCLES = CE_PULSE_CYC,
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned CFG_BITS = CFG_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link to device
  prs_link_if.host lnk,
  // user control
  input wire logic power_on,
  input wire logic reset_req,
  input wire logic need_synth_cfg,
  input wire logic [CFG_BITS-1:0] synth_cfg_word,
  // user status
  output logic dev_ready,
  output logic dev_running
);

  typedef struct packed {
    logic [1:0] por_s;
    logic [1:0] ack_s;
    logic [1:0] stable_s;
    logic [1:0] run_s;
    prs_host_state_t state;
    logic [31:0] cnt;
    logic ce;
    logic comm;
    logic valid;
    logic [CFG_BITS-1:0] data;
    logic full;
    logic ready;
    logic running;
  } prs_host_reg_t;

  prs_host_reg_t r;
  prs_host_reg_t n;

  always_comb begin
    n = r;
    n.por_s = {r.por_s[0], lnk.por_done};
    n.ack_s = {r.ack_s[0], lnk.cfg_ack};
    n.stable_s = {r.stable_s[0], lnk.clocks_stable};
    n.run_s = {r.run_s[0], lnk.blocks_run};

    if (!power_on) begin
      // enable low keeps the device off
      n.state = HS_OFF;
      n.ce = 1'b0;
      n.comm = 1'b0;
      n.valid = 1'b0;
      n.full = 1'b0;
      n.ready = 1'b0;
      n.running = 1'b0;
      n.cnt = 32'h0;
    end else if (reset_req && r.state != HS_OFF) begin
      // low pulse forces a fresh device reset
      n.state = HS_PULSE;
      n.ce = 1'b0;
      n.comm = 1'b0;
      n.valid = 1'b0;
      n.full = 1'b0;
      n.ready = 1'b0;
      n.running = 1'b0;
      n.cnt = 32'h0;
    end else begin
      case (r.state)
        HS_OFF: begin
          n.ce = 1'b1;
          n.state = HS_WAIT_POR;
        end
        HS_PULSE: begin
          n.cnt = r.cnt + 32'h1;
          if (r.cnt >= 32'(PULSE_CYCLES - 1)) begin
            n.ce = 1'b1;
            n.state = HS_WAIT_POR;
          end
        end
        HS_WAIT_POR: begin
          if (r.por_s[1]) begin
            // talk only after power-up reset is done
            n.ready = 1'b1;
            n.comm = 1'b1;
            n.cnt = 32'h0;
            if (need_synth_cfg) begin
              n.data = synth_cfg_word;
              n.state = HS_CFG;
            end else begin
              n.state = HS_SETTLE;
            end
          end
        end
        HS_CFG: begin
          n.valid = 1'b1;
          if (r.ack_s[1]) begin
            n.valid = 1'b0;
            n.state = HS_CFG_END;
          end
        end
        HS_CFG_END: begin
          if (!r.ack_s[1]) begin
            n.state = HS_SETTLE;
          end
        end
        HS_SETTLE: begin
          // settling counted from synth stable
          if (r.stable_s[1]) begin
            n.cnt = r.cnt + 32'h1;
            if (r.cnt >= 32'(SETTLE_CYCLES - 1)) begin
              n.full = 1'b1;
              n.state = HS_FULL;
            end
          end
        end
        HS_FULL: begin
          if (r.run_s[1]) begin
            n.running = 1'b1;
            n.state = HS_RUN;
          end
        end
        HS_RUN: begin
          n.running = r.run_s[1];
        end
        default: begin
          n.state = HS_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lnk.chip_enable_pin = r.ce;
  assign lnk.comm_req = r.comm;
  assign lnk.cfg_valid = r.valid;
  assign lnk.cfg_data = r.data;
  assign lnk.full_speed_sel = r.full;
  assign dev_ready = r.ready;
  assign dev_running = r.running;

endmodule // prs_host

// File: verification/prs_link_sva.sv
// link checker for the power-up reset sequencer
`timescale 1ns/100ps
module prs_link_sva #(
  parameter int unsigned POR_CYCLES = 20,
  parameter int unsigned SETTLE_CYCLES = 10,
  parameter int unsigned CFG_BITS = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host to device
  input wire logic chip_enable_pin,
  input wire logic comm_req,
  input wire logic cfg_valid,
  input wire logic [CFG_BITS-1:0] cfg_data,
  input wire logic full_speed_sel,
  // device to host
  input wire logic por_done,
  input wire logic cfg_ack,
  input wire logic clocks_stable,
  input wire logic blocks_run
);
  localparam int POR_HI = POR_CYCLES + 8;
  logic [31:0] ce_cnt_r;
  logic [31:0] stab_cnt_r;
  // cycles of enable high and of stable clocks
  always_ff @(posedge clk) begin
    ce_cnt_r <= (!rstn || !chip_enable_pin) ? 32'h0 : ce_cnt_r + 32'h1;
    stab_cnt_r <= (!rstn || !clocks_stable) ? 32'h0 : stab_cnt_r + 32'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_comm_start;
    $rose(comm_req) ##1 chip_enable_pin;
  endsequence
  sequence s_clocks_up;
    (!clocks_stable)[*8] ##[1:6] clocks_stable;
  endsequence
  off_quiet_a: assert property ((!chip_enable_pin)[*6] |->
    !por_done && !clocks_stable && !blocks_run) else $error("outputs active while disabled");
  por_window_a: assert property ($rose(por_done) |->
    ce_cnt_r >= POR_CYCLES && ce_cnt_r <= POR_HI) else $error("reset done at wrong time");
  por_bound_a: assert property ($rose(chip_enable_pin) |->
    ##[1:POR_HI] (por_done || !chip_enable_pin)) else $error("reset done too late");
  comm_after_por_a: assert property ($rose(comm_req) |-> por_done)
    else $error("communication before reset done");
  bringup_order_a: assert property (s_comm_start |-> s_clocks_up)
    else $error("clock bring-up timing wrong");
  run_gate_a: assert property ($rose(blocks_run) |-> $past(clocks_stable) && comm_req)
    else $error("blocks run before clocks stable");
  ack_rise_a: assert property ($rose(cfg_valid) |-> ##3 cfg_ack)
    else $error("setup word not acknowledged");
  ack_fall_a: assert property ($fell(cfg_valid) |-> cfg_ack[*3] ##1 !cfg_ack)
    else $error("acknowledge release wrong");
  data_hold_a: assert property (cfg_valid && !cfg_ack |=> $stable(cfg_data))
    else $error("setup word changed in handshake");
  settle_wait_a: assert property ($rose(full_speed_sel) |->
    stab_cnt_r >= SETTLE_CYCLES) else $error("full speed before settling");
  no_cfg_full_a: assert property (full_speed_sel |-> !cfg_valid)
    else $error("setup word after full speed");
endmodule // prs_link_sva

// File: verification/prs_tb.sv
// self-checking bench for both ends of the power-up reset sequencer
`timescale 1ns/100ps
module prs_tb;
  localparam int unsigned POR = 20;
  localparam int unsigned SETTLE = 10;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] sleep_req = 3'h0;
  logic [2:0] blk_clk_en;
  logic [2:0] blk_pwr_en;
  logic [2:0] blk_rst_n;
  logic xtal_en;
  logic frequency_synth_en;
  logic clk_full_sel;
  logic [31:0] frequency_synth_cfg;
  logic power_on = 1'b0;
  logic reset_req = 1'b0;
  logic need_synth_cfg = 1'b0;
  logic [31:0] synth_cfg_word = 32'h0;
  logic dev_ready;
  logic dev_running;
  int fails = 0;
  int comparisons = 0;
  always #4 clk = ~clk;
  prs_link_if lnk ();
  prs_device #(.POR_CYCLES(POR), .XTAL_CYCLES(4), .SYNTH_CYCLES(4)) i_prs_device (
    .clk(clk), .rstn(rstn), .lnk(lnk), .sleep_req(sleep_req), .blk_clk_en(blk_clk_en),
    .blk_pwr_en(blk_pwr_en), .blk_rst_n(blk_rst_n), .xtal_en(xtal_en),
    .frequency_synth_en(frequency_synth_en), .clk_full_sel(clk_full_sel),
    .frequency_synth_cfg(frequency_synth_cfg));
  prs_host #(.PULSE_CYCLES(8), .SETTLE_CYCLES(SETTLE)) i_prs_host (
    .clk(clk), .rstn(rstn), .lnk(lnk), .power_on(power_on), .reset_req(reset_req),
    .need_synth_cfg(need_synth_cfg), .synth_cfg_word(synth_cfg_word),
    .dev_ready(dev_ready), .dev_running(dev_running));
  prs_link_sva #(.POR_CYCLES(POR), .SETTLE_CYCLES(SETTLE)) i_prs_link_sva (
    .clk(clk), .rstn(rstn), .chip_enable_pin(lnk.chip_enable_pin), .comm_req(lnk.comm_req),
    .cfg_valid(lnk.cfg_valid), .cfg_data(lnk.cfg_data), .full_speed_sel(lnk.full_speed_sel),
    .por_done(lnk.por_done), .cfg_ack(lnk.cfg_ack), .clocks_stable(lnk.clocks_stable),
    .blocks_run(lnk.blocks_run));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // enable held low keeps the device dark
  task automatic t_off();
    cyc(30);
    check({lnk.chip_enable_pin, lnk.por_done, xtal_en, frequency_synth_en}, 4'h0);
    check({blk_pwr_en, blk_clk_en, blk_rst_n}, 9'h000);
  endtask
  // run to full speed, watching order on the way
  task automatic t_bringup(input logic cfg, input logic [31:0] word);
    int n;
    int np;
    int nx;
    int ns;
    n = 0;
    np = 0;
    nx = 0;
    ns = 0;
    while (dev_running !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
      np += (lnk.por_done !== 1'b1);
      nx += (xtal_en !== 1'b1);
      ns += (frequency_synth_en !== 1'b1);
      if (lnk.clocks_stable !== 1'b1) check({blk_rst_n, blk_clk_en}, 6'h00);
      if (lnk.full_speed_sel !== 1'b1) check(clk_full_sel, 1'b0);
    end
    check(n < 2000, 1'b1);
    cyc(4);
    check({dev_ready, dev_running}, 2'b11);
    check(np <= POR + 6, 1'b1);
    check(nx > np, 1'b1);
    check(ns - nx >= 4, 1'b1);
    check(frequency_synth_cfg, cfg ? word : 32'h0);
    check({clk_full_sel, blk_clk_en, blk_pwr_en, blk_rst_n}, 10'h3FF);
  endtask
  // each block sleeps: clock gated first, then power and reset
  task automatic t_sleep();
    for (int i = 0; i < 3; i++) begin
      sleep_req = 3'h1 << i;
      cyc(1);
      check({blk_clk_en[i], blk_pwr_en[i]}, 2'b01);
      cyc(4);
      check({blk_clk_en, blk_pwr_en, blk_rst_n}, {3{~(3'h1 << i)}});
      sleep_req = 3'h0;
      cyc(1);
      check({blk_clk_en[i], blk_pwr_en[i]}, 2'b01);
      cyc(3);
      check({blk_clk_en, blk_pwr_en, blk_rst_n}, 9'h1FF);
    end
  endtask
  // enable pulse restarts everything, setup word lost
  task automatic t_reset_pulse();
    need_synth_cfg = 1'b0;
    reset_req = 1'b1;
    cyc(1);
    reset_req = 1'b0;
    cyc(6);
    check({lnk.chip_enable_pin, lnk.por_done, lnk.blocks_run, xtal_en}, 4'h0);
    check({blk_pwr_en, blk_rst_n}, 6'h00);
    check({dev_ready, dev_running}, 2'b00);
    t_bringup(1'b0, 32'h0);
  endtask
  initial begin
    cyc(2);
    rstn = 1'b1;
    t_off();
    need_synth_cfg = 1'b1;
    synth_cfg_word = 32'hA5C30F1E;
    power_on = 1'b1;
    t_bringup(1'b1, 32'hA5C30F1E);
    t_sleep();
    t_reset_pulse();
    power_on = 1'b0;
    cyc(8);
    check({lnk.chip_enable_pin, lnk.por_done, xtal_en, blk_pwr_en}, 6'h00);
    report_and_stop();
  end
  // watchdog
  initial begin
    repeat (6000) @(posedge clk);
    fails++;
    report_and_stop();
  end
endmodule // prs_tb
